// File: cssv_pkg.sv
// Shared constants for the core status, stack pointer and vectoring block
package cssv_pkg;
  // Register offsets; printed offsets are not all multiples of four, so they are indices
  localparam logic [7:0] IDX_SP_LOW  = 8'h3d;
  localparam logic [7:0] IDX_SP_HIGH = 8'h3e;
  localparam logic [7:0] IDX_STATUS  = 8'h3f;
  localparam logic [7:0] IDX_CTRL    = 8'h40;
  localparam logic [7:0] IDX_VECTOR  = 8'h41;
  // Status bit positions
  localparam int ST_I = 7;
  localparam int ST_T = 6;
  localparam int ST_H = 5;
  localparam int ST_S = 4;
  localparam int ST_V = 3;
  localparam int ST_N = 2;
  localparam int ST_Z = 1;
  localparam int ST_C = 0;
  // Control register bit positions
  localparam int CTL_RELOC   = 0;
  localparam int CTL_APPLOCK = 1;
  localparam int CTL_BOOTLOCK = 2;
  // Reset values
  localparam logic [7:0]  STATUS_RST = 8'h00;
  localparam logic [11:0] SP_RST     = 12'h000;
  // Vector layout
  localparam int          NUM_SRC       = 19;
  localparam logic [15:0] RESET_VEC     = 16'h0000;
  localparam logic [15:0] VEC_BASE      = 16'h0002;
  localparam logic [15:0] BOOT_RST_ADDR = 16'h3800;
  localparam logic [1:0]  AXI_OKAY      = 2'b00;
  localparam logic [1:0]  AXI_SLVERR    = 2'b10;
  // Stack commands from the sequencer
  typedef enum logic [2:0] {
    CSSV_SP_NONE, CSSV_SP_PUSH, CSSV_SP_POP, CSSV_SP_CALL, CSSV_SP_RET
  } cssv_spop_t;
endpackage

// File: cssv_prio.sv
// Fixed-priority selector of the lowest pending vector
`timescale 1ns/1ps
`default_nettype none
module cssv_prio
  import cssv_pkg::*;
#(
  parameter int N = NUM_SRC
) (
  // Requests
  input  wire logic [N-1:0] req,
  // Result
  output logic              any,
  output logic [4:0]        idx
);
  always_comb begin
    any = 1'b0;
    idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = 5'(i);
      end
    end
  end
endmodule
`default_nettype wire

// File: cssv_sp.sv
// Twelve-bit stack pointer with sequencer adjust and byte writes
`timescale 1ns/1ps
`default_nettype none
module cssv_sp
  import cssv_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Sequencer
  input  wire cssv_spop_t  op,
  input  wire logic        irq_push,
  // Software byte writes
  input  wire logic        wr_low,
  input  wire logic        wr_high,
  input  wire logic [7:0]  wdata,
  // Value
  output logic [11:0]      sp
);
  logic [11:0] next_sp;
  always_comb begin
    next_sp = sp;
    if (irq_push) begin
      next_sp = sp - 12'h002;
    end else begin
      case (op)
        CSSV_SP_PUSH: next_sp = sp - 12'h001;
        CSSV_SP_CALL: next_sp = sp - 12'h002;
        CSSV_SP_POP:  next_sp = sp + 12'h001;
        CSSV_SP_RET:  next_sp = sp + 12'h002;
        default:      next_sp = sp;
      endcase
    end
    if (wr_low) next_sp[7:0] = wdata;
    if (wr_high) next_sp[11:8] = wdata[3:0];
  end
  always_ff @(posedge clk) begin
    if (rst) sp <= SP_RST;
    else sp <= next_sp;
  end
endmodule
`default_nettype wire

// File: cssv_core.sv
// Core status flags, stack pointer and interrupt vectoring with AXI4-Lite access
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module cssv_core
  import cssv_pkg::*;
#(
  parameter int          NSRC      = NUM_SRC,
  parameter logic [15:0] BOOT_ADDR = BOOT_RST_ADDR,
  parameter logic [15:0] BOOT_LIMIT = BOOT_RST_ADDR
) (
  // Clock and reset
  input  wire logic            MCLK,
  input  wire logic            RESET,
  // Fuse
  input  wire logic            BOOT_RESET_FUSE,
  // Peripheral requests and enables
  input  wire logic [NSRC-1:0] IRQ_REQ,
  input  wire logic [NSRC-1:0] IRQ_EN,
  output logic [NSRC-1:0]      IRQ_ACK,
  // Sequencer
  input  wire logic            INSTR_BOUNDARY,
  input  wire logic [15:0]     PC_NEXT,
  input  wire cssv_spop_t      SP_OP,
  input  wire logic            RETURN_FROM_IRQ_INSTR,
  input  wire logic            BIT_TO_FLAG_INSTR,
  input  wire logic            BIT_IN,
  input  wire logic            ALU_WE,
  input  wire logic [7:0]      ALU_MASK,
  input  wire logic            ALU_H,
  input  wire logic            ALU_V,
  input  wire logic            ALU_N,
  input  wire logic            ALU_Z,
  input  wire logic            ALU_C,
  output logic                 IRQ_TAKE,
  output logic [15:0]          IRQ_VECTOR,
  output logic [15:0]          IRQ_RET_PC,
  output logic [15:0]          RESET_FETCH,
  output logic                 FLAG_TO_BIT_VALUE,
  output logic [7:0]           STATUS,
  output logic [11:0]          STACK_POINTER,
  // AXI4-Lite slave
  input  wire logic [31:0]     S_AXI_AWADDR,
  input  wire logic            S_AXI_AWVALID,
  output logic                 S_AXI_AWREADY,
  input  wire logic [31:0]     S_AXI_WDATA,
  input  wire logic [3:0]      S_AXI_WSTRB,
  input  wire logic            S_AXI_WVALID,
  output logic                 S_AXI_WREADY,
  output logic [1:0]           S_AXI_BRESP,
  output logic                 S_AXI_BVALID,
  input  wire logic            S_AXI_BREADY,
  input  wire logic [31:0]     S_AXI_ARADDR,
  input  wire logic            S_AXI_ARVALID,
  output logic                 S_AXI_ARREADY,
  output logic [31:0]          S_AXI_RDATA,
  output logic [1:0]           S_AXI_RRESP,
  output logic                 S_AXI_RVALID,
  input  wire logic            S_AXI_RREADY
);
  // Bus write channel state
  logic        aw_held;
  logic [7:0]  aw_idx;
  logic        w_held;
  logic [31:0] w_data;
  logic        w_b0;
  logic        next_aw_held;
  logic [7:0]  next_aw_idx;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic        next_w_b0;
  logic [1:0]  next_bresp;
  logic        next_bvalid;
  logic        wr_fire;
  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx  = aw_idx;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_b0    = w_b0;
    next_bresp   = S_AXI_BRESP;
    next_bvalid  = S_AXI_BVALID;
    wr_fire      = 1'b0;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      next_aw_held = 1'b1;
      next_aw_idx  = S_AXI_AWADDR[9:2];
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      next_w_held = 1'b1;
      next_w_data = S_AXI_WDATA;
      next_w_b0   = S_AXI_WSTRB[0];
    end
    if (aw_held && w_held && !S_AXI_BVALID) begin
      wr_fire      = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_idx >= IDX_SP_LOW && aw_idx <= IDX_CTRL) ? AXI_OKAY : AXI_SLVERR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      next_bvalid = 1'b0;
    end
  end
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      aw_held      <= 1'b0;
      aw_idx       <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h00000000;
      w_b0         <= 1'b0;
      S_AXI_BRESP  <= AXI_OKAY;
      S_AXI_BVALID <= 1'b0;
    end else begin
      aw_held      <= next_aw_held;
      aw_idx       <= next_aw_idx;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_b0         <= next_w_b0;
      S_AXI_BRESP  <= next_bresp;
      S_AXI_BVALID <= next_bvalid;
    end
  end
  logic       sw_we;
  logic [7:0] sw_wd;
  assign sw_we = wr_fire && w_b0;
  assign sw_wd = w_data[7:0];
  // Control register: relocation and the two lock bits
  logic [2:0] ctrl;
  logic [2:0] next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (sw_we && aw_idx == IDX_CTRL) next_ctrl = sw_wd[2:0];
  end
  always_ff @(posedge MCLK) begin
    if (RESET) ctrl <= 3'h0;
    else ctrl <= next_ctrl;
  end
  // Interrupt selection
  logic [NSRC-1:0] live;
  logic            any_req;
  logic [4:0]      win;
  logic            in_boot;
  logic            locked;
  assign in_boot = PC_NEXT >= BOOT_LIMIT;
  // Application lock blocks while in application; boot lock blocks while in boot
  assign locked = (ctrl[CTL_APPLOCK] && !in_boot) || (ctrl[CTL_BOOTLOCK] && in_boot);
  assign live = IRQ_REQ & IRQ_EN & {NSRC{STATUS[ST_I]}};
  cssv_prio #(.N(NSRC)) u_prio (
    .req (live),
    .any (any_req),
    .idx (win)
  );
  logic take;
  assign take = any_req && INSTR_BOUNDARY && !locked;
  // Status register
  logic [7:0] next_status;
  always_comb begin
    next_status = STATUS;
    if (ALU_WE) begin
      if (ALU_MASK[ST_H]) next_status[ST_H] = ALU_H;
      if (ALU_MASK[ST_V]) next_status[ST_V] = ALU_V;
      if (ALU_MASK[ST_N]) next_status[ST_N] = ALU_N;
      if (ALU_MASK[ST_Z]) next_status[ST_Z] = ALU_Z;
      if (ALU_MASK[ST_C]) next_status[ST_C] = ALU_C;
    end
    if (BIT_TO_FLAG_INSTR) next_status[ST_T] = BIT_IN;
    if (RETURN_FROM_IRQ_INSTR) next_status[ST_I] = 1'b1;
    if (sw_we && aw_idx == IDX_STATUS) next_status = sw_wd;
    if (take) next_status[ST_I] = 1'b0;
    next_status[ST_S] = next_status[ST_N] ^ next_status[ST_V];
  end
  always_ff @(posedge MCLK) begin
    if (RESET) STATUS <= STATUS_RST;
    else STATUS <= next_status;
  end
  assign FLAG_TO_BIT_VALUE = STATUS[ST_T];
  // Stack pointer
  cssv_sp u_sp (
    .clk      (MCLK),
    .rst      (RESET),
    .op       (SP_OP),
    .irq_push (take),
    .wr_low   (sw_we && aw_idx == IDX_SP_LOW),
    .wr_high  (sw_we && aw_idx == IDX_SP_HIGH),
    .wdata    (sw_wd),
    .sp       (STACK_POINTER)
  );
  // Vector generation
  logic [15:0] next_vector;
  logic [15:0] vec_base;
  assign vec_base = ctrl[CTL_RELOC] ? (BOOT_ADDR + VEC_BASE) : VEC_BASE;
  assign next_vector = vec_base + {10'h000, win, 1'b0};
  assign RESET_FETCH = BOOT_RESET_FUSE ? BOOT_ADDR : RESET_VEC;
  logic [NSRC-1:0] next_ack;
  always_comb begin
    next_ack = '0;
    if (take) next_ack[win] = 1'b1;
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      IRQ_TAKE   <= 1'b0;
      IRQ_VECTOR <= 16'h0000;
      IRQ_RET_PC <= 16'h0000;
      IRQ_ACK    <= '0;
    end else begin
      IRQ_TAKE   <= take;
      IRQ_VECTOR <= take ? next_vector : IRQ_VECTOR;
      IRQ_RET_PC <= take ? PC_NEXT : IRQ_RET_PC;
      IRQ_ACK    <= next_ack;
    end
  end
  // Bus read channel
  logic [31:0] rd_word;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  always_comb begin
    case (S_AXI_ARADDR[9:2])
      IDX_SP_LOW:  rd_word = {24'h000000, STACK_POINTER[7:0]};
      IDX_SP_HIGH: rd_word = {28'h0000000, STACK_POINTER[11:8]};
      IDX_STATUS:  rd_word = {24'h000000, STATUS};
      IDX_CTRL:    rd_word = {29'h00000000, ctrl};
      IDX_VECTOR:  rd_word = {16'h0000, IRQ_VECTOR};
      default:     rd_word = 32'h00000000;
    endcase
    next_rdata  = S_AXI_RDATA;
    next_rresp  = S_AXI_RRESP;
    next_rvalid = S_AXI_RVALID;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      next_rdata  = rd_word;
      next_rvalid = 1'b1;
      next_rresp  = (S_AXI_ARADDR[9:2] >= IDX_SP_LOW && S_AXI_ARADDR[9:2] <= IDX_VECTOR)
                    ? AXI_OKAY : AXI_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      next_rvalid = 1'b0;
    end
  end
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      S_AXI_RDATA  <= 32'h00000000;
      S_AXI_RRESP  <= AXI_OKAY;
      S_AXI_RVALID <= 1'b0;
    end else begin
      S_AXI_RDATA  <= next_rdata;
      S_AXI_RRESP  <= next_rresp;
      S_AXI_RVALID <= next_rvalid;
    end
  end
  // Checks
  property p_mask;
    @(posedge MCLK) disable iff (RESET) !STATUS[ST_I] |-> !take;
  endproperty
  a_mask: assert property (p_mask) else $error("taken while globally masked");
  property p_entry_clears;
    @(posedge MCLK) disable iff (RESET) take |=> !STATUS[ST_I] && IRQ_TAKE;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("enable not cleared");
  property p_sign;
    @(posedge MCLK) disable iff (RESET) ##1 STATUS[ST_S] == (STATUS[ST_N] ^ STATUS[ST_V]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_tbit;
    @(posedge MCLK) disable iff (RESET)
      BIT_TO_FLAG_INSTR && !(sw_we && aw_idx == IDX_STATUS) |=> FLAG_TO_BIT_VALUE == $past(BIT_IN);
  endproperty
  a_tbit: assert property (p_tbit) else $error("copy bit wrong");
  property p_carry;
    @(posedge MCLK) disable iff (RESET)
      ALU_WE && ALU_MASK[ST_C] && !(sw_we && aw_idx == IDX_STATUS) |=> STATUS[ST_C] == $past(ALU_C);
  endproperty
  a_carry: assert property (p_carry) else $error("carry wrong");
  property p_sp_irq;
    @(posedge MCLK) disable iff (RESET)
      take && !sw_we |=> STACK_POINTER == $past(STACK_POINTER) - 12'h002;
  endproperty
  a_sp_irq: assert property (p_sp_irq) else $error("entry push wrong");
  property p_vec;
    @(posedge MCLK) disable iff (RESET)
      take && !ctrl[CTL_RELOC] |=> IRQ_VECTOR == VEC_BASE + {10'h000, $past(win), 1'b0};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_lock;
    @(posedge MCLK) disable iff (RESET) locked |-> !take;
  endproperty
  a_lock: assert property (p_lock) else $error("taken while locked");
  property p_prio;
    @(posedge MCLK) disable iff (RESET) take && live[0] |-> win == 5'h00;
  endproperty
  a_prio: assert property (p_prio) else $error("priority wrong");
  property p_rst;
    @(posedge MCLK) disable iff (RESET) RESET_FETCH == (BOOT_RESET_FUSE ? BOOT_ADDR : RESET_VEC);
  endproperty
  a_rst: assert property (p_rst) else $error("reset fetch wrong");
  property p_ret_sets;
    @(posedge MCLK) disable iff (RESET)
      RETURN_FROM_IRQ_INSTR && !take && !(sw_we && aw_idx == IDX_STATUS) |=> STATUS[ST_I];
  endproperty
  a_ret_sets: assert property (p_ret_sets) else $error("enable not set on return");
  property p_sp_push;
    @(posedge MCLK) disable iff (RESET)
      SP_OP == CSSV_SP_PUSH && !take && !sw_we
      |=> STACK_POINTER == $past(STACK_POINTER) - 12'h001;
  endproperty
  a_sp_push: assert property (p_sp_push) else $error("data push wrong");
  property p_sp_pop;
    @(posedge MCLK) disable iff (RESET)
      SP_OP == CSSV_SP_POP && !take && !sw_we
      |=> STACK_POINTER == $past(STACK_POINTER) + 12'h001;
  endproperty
  a_sp_pop: assert property (p_sp_pop) else $error("data pop wrong");
  property p_reloc;
    @(posedge MCLK) disable iff (RESET)
      take && ctrl[CTL_RELOC]
      |=> IRQ_VECTOR == BOOT_ADDR + VEC_BASE + {10'h000, $past(win), 1'b0};
  endproperty
  a_reloc: assert property (p_reloc) else $error("relocated vector wrong");
  property p_ack;
    @(posedge MCLK) disable iff (RESET) IRQ_TAKE |-> $onehot(IRQ_ACK);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge not one-hot");
  property p_retpc;
    @(posedge MCLK) disable iff (RESET) take |=> IRQ_RET_PC == $past(PC_NEXT);
  endproperty
  a_retpc: assert property (p_retpc) else $error("return address wrong");
endmodule
`default_nettype wire

// File: cssv_periph.sv
// Peripheral request sources that hold each flag until it is acknowledged
`timescale 1ns/1ps
`default_nettype none
module cssv_periph
  import cssv_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Event strobes and acknowledge
  input  wire logic [NUM_SRC-1:0] set_req,
  input  wire logic [NUM_SRC-1:0] ack,
  // Held requests
  output logic [NUM_SRC-1:0]      req
);
  logic [NUM_SRC-1:0] next_req;
  always_comb begin
    next_req = (req & ~ack) | set_req;
    if (rst) begin
      next_req = '0;
    end
  end
  always_ff @(posedge clk) begin
    req <= next_req;
  end
endmodule
`default_nettype wire

// File: cssv_core_tb_top.sv
// Self-checking bench for the core status, stack and vectoring block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", nm, e, a); end end
module cssv_core_tb_top;
  import cssv_pkg::*;
  localparam logic [15:0] VTAB [NUM_SRC] = '{16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000a,
    16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c,
    16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026};
  logic        mclk;
  logic        rst = 1'b1, fuse = 1'b0, bnd = 1'b0, rfi = 1'b0, b2f = 1'b0, bit_in = 1'b0;
  logic        alu_we = 1'b0, h = 1'b0, v = 1'b0, n = 1'b0, z = 1'b0, c = 1'b0;
  logic [18:0] en = '0, setr = '0, req, ack, cack;
  logic [15:0] pc = '0, vec, rpc, rfetch, cvec, crpc, exp;
  cssv_spop_t  spop = CSSV_SP_NONE;
  logic [7:0]  amask = '0, st, cst;
  logic [11:0] sp, csp, esp;
  logic        take, f2b, awr, wrdy, bv, arr, rv;
  logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, rval;
  logic [3:0]  wstrb = 4'h1;
  logic [1:0]  bresp, rresp, resp;
  int          bad_count = 0;
  int          checks_done = 0;
  int          ntake;
  cssv_spop_t  ops [4] = '{CSSV_SP_PUSH, CSSV_SP_CALL, CSSV_SP_POP, CSSV_SP_RET};
  logic [11:0] dl [4] = '{12'hfff, 12'hffe, 12'h001, 12'h002};

  cssv_core u_cssv_core (
    .MCLK(mclk), .RESET(rst), .BOOT_RESET_FUSE(fuse), .IRQ_REQ(req), .IRQ_EN(en),
    .IRQ_ACK(ack), .INSTR_BOUNDARY(bnd), .PC_NEXT(pc), .SP_OP(spop),
    .RETURN_FROM_IRQ_INSTR(rfi), .BIT_TO_FLAG_INSTR(b2f), .BIT_IN(bit_in), .ALU_WE(alu_we),
    .ALU_MASK(amask), .ALU_H(h), .ALU_V(v), .ALU_N(n), .ALU_Z(z), .ALU_C(c),
    .IRQ_TAKE(take), .IRQ_VECTOR(vec), .IRQ_RET_PC(rpc), .RESET_FETCH(rfetch),
    .FLAG_TO_BIT_VALUE(f2b), .STATUS(st), .STACK_POINTER(sp),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready));
  cssv_periph u_cssv_periph (.clk(mclk), .rst(rst), .set_req(setr), .ack(ack), .req(req));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task done(input string s);
    $display("test %s finished", s);
  endtask

  task wr(input logic [7:0] idx, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [7:0] idx);
    @(posedge mclk);
    araddr <= {22'h0, idx, 2'b00};
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arv && arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rval = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // Boundary held for cyc cycles; the last take is captured
  task watch(input int cyc);
    ntake = 0;
    @(posedge mclk) bnd <= 1'b1;
    repeat (cyc) begin
      @(negedge mclk);
      if (take === 1'b1) begin
        ntake++;
        {cvec, cack, cst, csp, crpc} = {vec, ack, st, sp, rpc};
      end
    end
    @(posedge mclk) bnd <= 1'b0;
  endtask

  task try(input logic [7:0] s, input logic [18:0] e, input logic [2:0] ct,
           input logic [15:0] p);
    wr(IDX_STATUS, s);
    wr(IDX_CTRL, {5'h0, ct});
    @(posedge mclk);
    en <= e;
    pc <= p;
    setr <= 19'h20;
    @(posedge mclk);
    setr <= '0;
    watch(8);
  endtask

  task alu(input logic [4:0] hvnzc, input logic [5:0] e);
    @(posedge mclk);
    alu_we <= 1'b1;
    amask <= 8'h2f;
    {h, v, n, z, c} <= hvnzc;
    @(posedge mclk);
    alu_we <= 1'b0;
    @(negedge mclk);
    `CHK("flags", e, st[5:0])
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    rd(IDX_SP_HIGH);
    `CHK("sp_high_rst", 32'h0, rval)
    wr(IDX_SP_HIGH, 8'hf8);
    rd(IDX_SP_HIGH);
    `CHK("sp_high", 32'h8, rval)
    wr(IDX_SP_LOW, 8'h5f);
    `CHK("wr_resp", AXI_OKAY, resp)
    en <= '1;
    for (int i = 0; i < NUM_SRC; i++) begin
      wr(IDX_CTRL, {7'h0, i[0]});
      wr(IDX_STATUS, 8'hd5);
      @(posedge mclk);
      setr <= 19'h3 << i;
      pc <= 16'h0100 + 16'(i);
      @(posedge mclk);
      setr <= '0;
      watch(8);
      exp = VTAB[i] + (i[0] ? BOOT_RST_ADDR : 16'h0000);
      `CHK("takes", 1, ntake)
      `CHK("vector", exp, cvec)
      `CHK("ack", 19'h1 << i, cack)
      `CHK("status", 8'h55, cst)
      `CHK("stack", 12'h85d, csp)
      `CHK("ret_pc", 16'h0100 + 16'(i), crpc)
      @(posedge mclk);
      rfi <= 1'b1;
      spop <= CSSV_SP_RET;
      @(posedge mclk);
      rfi <= 1'b0;
      spop <= CSSV_SP_NONE;
      @(negedge mclk);
      `CHK("status_ret", 8'hd5, st)
      `CHK("stack_ret", 12'h85f, sp)
    end
    done("vectors");
    esp = 12'h85f;
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk) spop <= ops[k];
      @(posedge mclk) spop <= CSSV_SP_NONE;
      @(negedge mclk);
      esp = esp + dl[k];
      `CHK("sp_op", esp, sp)
    end
    done("stack");
    try(8'h55, '1, 3'h0, 16'h0100);
    `CHK("global_off", 0, ntake)
    try(8'hd5, ~19'h20, 3'h0, 16'h0100);
    `CHK("source_off", 0, ntake)
    try(8'hd5, '1, 3'h2, 16'h0100);
    `CHK("app_lock", 0, ntake)
    try(8'hd5, '1, 3'h4, 16'h3900);
    `CHK("boot_lock", 0, ntake)
    try(8'hd5, '1, 3'h2, 16'h3900);
    `CHK("unlocked", 1, ntake)
    `CHK("unlocked_vec", 16'h000c, cvec)
    rd(IDX_VECTOR);
    `CHK("vec_rd", 32'h0000000c, rval)
    `CHK("rd_resp", AXI_OKAY, resp)
    rd(IDX_STATUS);
    `CHK("status_rd", 32'h00000055, rval)
    rd(IDX_CTRL);
    `CHK("ctrl_rd", 32'h00000002, rval)
    done("masking");
    alu(5'b11011, 6'b111011);
    alu(5'b01100, 6'b001100);
    alu(5'b00100, 6'b010100);
    for (int b = 1; b >= 0; b--) begin
      @(posedge mclk);
      b2f <= 1'b1;
      bit_in <= b[0];
      @(posedge mclk) b2f <= 1'b0;
      @(negedge mclk);
      `CHK("copy_bit", b[0], st[ST_T])
      `CHK("copy_out", b[0], f2b)
    end
    done("flags");
    wr(8'h50, 8'haa);
    `CHK("unmapped_wr", AXI_SLVERR, resp)
    rd(8'h50);
    `CHK("unmapped_rd", AXI_SLVERR, resp)
    `CHK("unmapped_data", 32'h0, rval)
    @(posedge mclk) fuse <= 1'b1;
    @(negedge mclk);
    `CHK("boot_fetch", BOOT_RST_ADDR, rfetch)
    @(posedge mclk) fuse <= 1'b0;
    @(negedge mclk);
    `CHK("app_fetch", 16'h0000, rfetch)
    @(posedge mclk) rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    `CHK("status_rst", STATUS_RST, st)
    `CHK("sp_rst", SP_RST, sp)
    rd(IDX_SP_LOW);
    `CHK("sp_low_rst", 32'h0, rval)
    done("reset");
    summarize();
  end
endmodule
`default_nettype wire
